//--- design/sfw_pkg.sv
// shared constants and types for the spi f-ram write protection block
package sfw_pkg;

  // ==========================================================================
  // command opcodes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06; // write_enable_cmd
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04; // write_disable_cmd
  localparam logic [7:0] OP_STATUS_READ   = 8'h05; // status_read_cmd
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01; // status_write_cmd
  localparam logic [7:0] OP_ARRAY_WRITE   = 8'h02; // array data write
  localparam logic [7:0] OP_SECTOR_WRITE  = 8'h42; // special sector write
  localparam logic [7:0] OP_SERIAL_WRITE  = 8'hc2; // serial number write

  // ==========================================================================
  // status register field positions
  localparam int unsigned SR_PIN_EN_BIT = 7; // protect_pin_enable
  localparam int unsigned SR_FIXED1_BIT = 6; // always one
  localparam int unsigned SR_BP_HI_BIT  = 3; // block_protect_hi
  localparam int unsigned SR_BP_LO_BIT  = 2; // block_protect_lo
  localparam int unsigned SR_WEL_BIT    = 1; // write_enable_latch
  localparam int unsigned SR_READY_BIT  = 0; // wake-up indication

  // ==========================================================================
  // reset and shipped values
  localparam logic       WEL_RESET     = 1'b0;  // latch cleared at power-up
  localparam logic       PIN_EN_SHIP   = 1'b0;  // shipped protect_pin_enable
  localparam logic [1:0] BP_SHIP       = 2'h0;  // shipped block protect field
  localparam logic [2:0] BIT_CNT_RESET = 3'h0;  // bit position at selection
  localparam logic [2:0] BIT_CNT_LAST  = 3'h7;  // eighth bit of a byte
  localparam logic [1:0] ADDR_BYTES_LAST = 2'h2; // third address byte

  // ==========================================================================
  // protected range start addresses
  localparam logic [19:0] PROT_QUARTER_START = 20'hc0000;
  localparam logic [19:0] PROT_HALF_START    = 20'h80000;
  localparam logic [19:0] PROT_ALL_START     = 20'h00000;

  // ==========================================================================
  // command phase of the serial engine
  typedef enum logic [2:0] {
    PH_OPCODE  = 3'b000, // waiting for the opcode byte
    PH_ADDRESS = 3'b001, // collecting three address bytes
    PH_WDATA   = 3'b010, // array data bytes
    PH_SR_READ = 3'b011, // shifting the status byte out
    PH_SR_WR   = 3'b100, // collecting the status data byte
    PH_IGNORE  = 3'b101  // rest of frame is ignored
  } sfw_phase_e;

endpackage : sfw_pkg

//--- design/sfw_protect.sv
// status register and write protection logic of the serial f-ram
`timescale 1ns/10ps

// Contract
// - write-disable opcode clears write enable latch
// - status layout: pin enable, protect bits, latch
// - bit zero ignores writes, reads the wake indication
// - bits four, five ignore writes, read zero
// - bit six ignores writes, reads one
// - latch cleared after every power-up
// - status data byte never writes the latch bit
// - protect bits non-volatile, shipped as zero
// - protect field selects quarter, half, all
// - only latch and range block array writes
// - pin low rejects status writes when enabled
// - status protected: pin-enabled-and-low or latch clear
// - status read shifts status out msb first
// - status write updates enable and protect bits
// - status write clears latch on completion
// - bit zero nonzero only while waking up
// - array writes at bus speed, no busy
// - write-enable opcode sets the latch
// - chip-select rise after write commands clears latch
// - protected address stops burst, discards data
module sfw_protect #(
  parameter int unsigned ADDR_W = 20 // array address width
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // spi pins, asynchronous to clk
  input  wire logic              cs_n,
  input  wire logic              sck,
  input  wire logic              si,
  input  wire logic              wp_n,
  output logic                   so,
  output logic                   so_oe,
  // non-volatile restore and wake indication, same clock domain
  input  wire logic              nv_load,
  input  wire logic [2:0]        nv_value,
  input  wire logic              wake_busy,
  // array write port
  output logic                   mem_wr_en,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [7:0]             mem_wdata,
  // status view
  output logic [7:0]             protection_status
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic                 cs_m, cs_s, cs_d;    // chip select sync and delay
    logic                 sck_m, sck_s, sck_d; // serial clock sync and delay
    logic                 si_m, si_s;          // serial input sync
    logic                 wp_m, wp_s;          // protect pin sync
    sfw_pkg::sfw_phase_e  phase;               // command phase
    logic [2:0]           bit_cnt;             // bit inside current byte
    logic [1:0]           byte_cnt;            // address byte count
    logic [7:0]           rx;                  // receive shifter
    logic [7:0]           tx;                  // status transmit shifter
    logic [ADDR_W-1:0]    addr;                // running array address
    logic                 halted;              // burst stopped at protected area
    logic                 clr_pend;            // latch clears at deselect
    logic [7:0]           sr_data;             // received status byte
    logic                 sr_full;             // status byte complete
    logic                 write_enable_latch;                 // write_enable_latch
    logic                 pin_en;              // protect_pin_enable
    logic [1:0]           bp;                  // block_protect_hi, block_protect_lo
    logic                 so;                  // serial output bit
    logic                 so_oe;               // serial output enable
    logic                 wr_en;               // array write pulse
    logic [ADDR_W-1:0]    waddr;               // array write address
    logic [7:0]           wdata;               // array write data
  } sfw_state_s;

  sfw_state_s r_reg;  // registered state
  sfw_state_s r_next; // next state

  // ==========================================================================
  // helpers
  // true when an address lies in the range that the protect field selects
  function automatic logic addr_protected(input logic [1:0] bp,
                                          input logic [ADDR_W-1:0] a);
    logic [19:0] a20;
    a20 = 20'(a);
    unique case (bp)
      2'h0: addr_protected = 1'b0;
      2'h1: addr_protected = (a20 >= sfw_pkg::PROT_QUARTER_START);
      2'h2: addr_protected = (a20 >= sfw_pkg::PROT_HALF_START);
      2'h3: addr_protected = (a20 >= sfw_pkg::PROT_ALL_START);
    endcase
  endfunction : addr_protected

  logic       sck_rise;   // serial clock rising edge, selected
  logic       sck_fall;   // serial clock falling edge, selected
  logic       cs_rise;    // deselect edge
  logic       selected;   // chip select active
  logic [7:0] rx_byte;    // byte including the bit now sampled
  logic       byte_done;  // eighth rising edge of a byte
  logic       sr_permit;  // status register writable now
  logic [7:0] status_now; // status byte as read
  logic       write_enable_cmd_hit;   // write-enable opcode completes
  logic       write_disable_cmd_hit;   // write-disable opcode completes
  logic       sr_commit;  // status update applied this cycle

  // ==========================================================================
  // decode of edges and status view
  always_comb begin
    selected   = ~r_reg.cs_s;
    sck_rise   = selected & r_reg.sck_s & ~r_reg.sck_d;
    sck_fall   = selected & ~r_reg.sck_s & r_reg.sck_d;
    cs_rise    = r_reg.cs_s & ~r_reg.cs_d;
    rx_byte    = {r_reg.rx[6:0], r_reg.si_s};
    byte_done  = sck_rise & (r_reg.bit_cnt == sfw_pkg::BIT_CNT_LAST);
    // pin only counts while its enable is set
    sr_permit  = r_reg.write_enable_latch & ~(r_reg.pin_en & ~r_reg.wp_s);
    status_now = 8'h00;
    status_now[sfw_pkg::SR_PIN_EN_BIT] = r_reg.pin_en;
    status_now[sfw_pkg::SR_FIXED1_BIT] = 1'b1;
    status_now[sfw_pkg::SR_BP_HI_BIT]  = r_reg.bp[1];
    status_now[sfw_pkg::SR_BP_LO_BIT]  = r_reg.bp[0];
    status_now[sfw_pkg::SR_WEL_BIT]    = r_reg.write_enable_latch;
    status_now[sfw_pkg::SR_READY_BIT]  = wake_busy;
    write_enable_cmd_hit  = byte_done & (r_reg.phase == sfw_pkg::PH_OPCODE)
                & (rx_byte == sfw_pkg::OP_WRITE_ENABLE);
    write_disable_cmd_hit  = byte_done & (r_reg.phase == sfw_pkg::PH_OPCODE)
                & (rx_byte == sfw_pkg::OP_WRITE_DISABLE);
    sr_commit = cs_rise & (r_reg.phase == sfw_pkg::PH_SR_WR) & r_reg.sr_full & sr_permit;
  end

  // ==========================================================================
  // next state
  always_comb begin
    r_next = r_reg;
    // two flip-flops on every pin before any logic looks at it
    r_next.cs_m  = cs_n;
    r_next.cs_s  = r_reg.cs_m;
    r_next.cs_d  = r_reg.cs_s;
    r_next.sck_m = sck;
    r_next.sck_s = r_reg.sck_m;
    r_next.sck_d = r_reg.sck_s;
    r_next.si_m  = si;
    r_next.si_s  = r_reg.si_m;
    r_next.wp_m  = wp_n;
    r_next.wp_s  = r_reg.wp_m;
    r_next.wr_en = 1'b0;
    // restore of the non-volatile bits after power-up
    if (nv_load) begin
      r_next.pin_en = nv_value[2];
      r_next.bp     = nv_value[1:0];
    end
    if (!selected) begin
      // deselected: frame state returns to idle
      r_next.phase    = sfw_pkg::PH_OPCODE;
      r_next.bit_cnt  = sfw_pkg::BIT_CNT_RESET;
      r_next.byte_cnt = 2'h0;
      r_next.so_oe    = 1'b0;
      r_next.halted   = 1'b0;
      r_next.sr_full  = 1'b0;
      r_next.clr_pend = 1'b0;
      if (sr_commit) begin
        // only enable and protect bits are taken, latch bit ignored
        r_next.pin_en = r_reg.sr_data[sfw_pkg::SR_PIN_EN_BIT];
        r_next.bp     = {r_reg.sr_data[sfw_pkg::SR_BP_HI_BIT],
                         r_reg.sr_data[sfw_pkg::SR_BP_LO_BIT]};
      end
      if (cs_rise && r_reg.clr_pend) begin
        r_next.write_enable_latch = 1'b0;
      end
    end else begin
      if (sck_rise) begin
        r_next.rx      = rx_byte;
        r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
      end
      // status bits leave on falling edges, msb first, repeating
      if (sck_fall && r_reg.phase == sfw_pkg::PH_SR_READ) begin
        r_next.so    = r_reg.tx[7];
        r_next.tx    = {r_reg.tx[6:0], r_reg.tx[7]};
        r_next.so_oe = 1'b1;
      end
      if (byte_done) begin
        unique case (r_reg.phase)
          sfw_pkg::PH_OPCODE: begin
            r_next.phase = sfw_pkg::PH_IGNORE; // unknown opcodes ignore the frame
            unique case (rx_byte)
              sfw_pkg::OP_WRITE_ENABLE: begin
                r_next.write_enable_latch = 1'b1;
              end
              sfw_pkg::OP_WRITE_DISABLE: begin
                r_next.write_enable_latch      = 1'b0;
                r_next.clr_pend = 1'b1;
              end
              sfw_pkg::OP_STATUS_READ: begin
                r_next.tx    = status_now;
                r_next.phase = sfw_pkg::PH_SR_READ;
              end
              sfw_pkg::OP_STATUS_WRITE: begin
                r_next.clr_pend = 1'b1;
                r_next.phase    = sfw_pkg::PH_SR_WR;
              end
              sfw_pkg::OP_ARRAY_WRITE: begin
                r_next.clr_pend = 1'b1;
                r_next.phase    = sfw_pkg::PH_ADDRESS;
              end
              sfw_pkg::OP_SECTOR_WRITE, sfw_pkg::OP_SERIAL_WRITE: begin
                r_next.clr_pend = 1'b1;
              end
              default: begin
                r_next.clr_pend = r_reg.clr_pend;
              end
            endcase
          end
          sfw_pkg::PH_ADDRESS: begin
            // upper bits beyond the array width drop out of the shift
            r_next.addr     = ADDR_W'({r_reg.addr, rx_byte});
            r_next.byte_cnt = r_reg.byte_cnt + 2'h1;
            if (r_reg.byte_cnt == sfw_pkg::ADDR_BYTES_LAST) begin
              r_next.phase = sfw_pkg::PH_WDATA;
            end
          end
          sfw_pkg::PH_WDATA: begin
            // each byte goes out at once; the pin never blocks the array
            if (r_reg.write_enable_latch && !r_reg.halted && !addr_protected(r_reg.bp, r_reg.addr)) begin
              r_next.wr_en = 1'b1;
              r_next.waddr = r_reg.addr;
              r_next.wdata = rx_byte;
              r_next.addr  = r_reg.addr + ADDR_W'(1);
            end else begin
              r_next.halted = 1'b1;
            end
          end
          sfw_pkg::PH_SR_WR: begin
            // first data byte only; later bytes are dropped
            if (!r_reg.sr_full) begin
              r_next.sr_data = rx_byte;
              r_next.sr_full = 1'b1;
            end
          end
          default: begin
            r_next.phase = r_reg.phase;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // state register; protect bits start from shipped values until restored
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r_reg        <= '0;
      r_reg.cs_m   <= 1'b1;
      r_reg.cs_s   <= 1'b1;
      r_reg.cs_d   <= 1'b1;
      r_reg.wp_m   <= 1'b1;
      r_reg.wp_s   <= 1'b1;
      r_reg.phase  <= sfw_pkg::PH_OPCODE;
      r_reg.write_enable_latch    <= sfw_pkg::WEL_RESET;
      r_reg.pin_en <= sfw_pkg::PIN_EN_SHIP;
      r_reg.bp     <= sfw_pkg::BP_SHIP;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // outputs
  assign so                = r_reg.so;
  assign so_oe             = r_reg.so_oe;
  assign mem_wr_en         = r_reg.wr_en;
  assign mem_addr          = r_reg.waddr;
  assign mem_wdata         = r_reg.wdata;
  assign protection_status = status_now;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  fixed_bits_a: assert property (protection_status[5:4] == 2'h0 && protection_status[6])
    else $error("fixed status bits wrong");
  ready_bit_a: assert property (protection_status[0] == wake_busy)
    else $error("status bit zero not tied to wake indication");
  wel_set_a: assert property (write_enable_cmd_hit |=> protection_status[1])
    else $error("write enable did not set latch");
  wel_clear_a: assert property (write_disable_cmd_hit |=> !protection_status[1])
    else $error("write disable did not clear latch");
  wel_rise_a: assert property ($rose(r_reg.write_enable_latch) |-> $past(write_enable_cmd_hit))
    else $error("latch set without write enable");
  deselect_clear_a: assert property (cs_rise && r_reg.clr_pend |=> !r_reg.write_enable_latch)
    else $error("latch survived end of write command");
  pin_block_a: assert property (cs_rise && r_reg.pin_en && !r_reg.wp_s
                                |=> $stable(protection_status[7:2]))
    else $error("status changed with pin protection active");
  sr_change_a: assert property ($changed(r_reg.bp) |-> $past(sr_commit || nv_load, 1))
    else $error("protect bits changed without a status write");
  array_guard_a: assert property ($rose(mem_wr_en) |-> r_reg.write_enable_latch
                                  && !addr_protected(r_reg.bp, mem_addr))
    else $error("array write while protected");
  sr_read_a: assert property (so_oe |-> r_reg.phase == sfw_pkg::PH_SR_READ)
    else $error("output driven outside status read");

  write_enable_cmd_c: cover property (write_enable_cmd_hit);
  commit_c: cover property (sr_commit);
  array_c: cover property (mem_wr_en ##[1:200] mem_wr_en);
  halt_c: cover property ($rose(r_reg.halted));

endmodule : sfw_protect

//--- bench/sfw_spi_master.sv
// serial bus master model that drives the pins of the protection block
`timescale 1ns/10ps

// ============================================================================
// mode 0 master: sck idles low, si moves while sck is low, so taken on sck rise
module sfw_spi_master #(
  parameter time HALF_SCK = 32ns // delay part of a half step; with the clk-edge wait the link clock is 70 ns
) (
  // system clock, used only to launch pin changes
  input  wire logic clk,
  // spi pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  // pins idle deselected with the clock low
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // wait half a link period, then change pins just after a clock edge
  task automatic half_step();
    #(HALF_SCK);
    @(posedge clk);
  endtask : half_step

  // select the device; sck low here so mode 0 is the one detected
  task automatic select();
    half_step();
    cs_n <= 1'b0;
  endtask : select

  // one byte each way, most significant bit first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si <= tx[i];
      half_step();
      sck   <= 1'b1;
      rx[i] = so; // so settled long before this edge
      half_step();
      sck <= 1'b0;
    end
  endtask : xfer

  // deselect, then keep cs high well beyond the three clocks asked for
  task automatic deselect();
    half_step();
    cs_n <= 1'b1;
    si   <= ~si; // released line must not look like the last bit
    repeat (10) @(posedge clk);
  endtask : deselect
endmodule : sfw_spi_master

//--- bench/sfw_protect_tb_top.sv
// self-checking bench for the protection block, driven by the serial master model
`timescale 1ns/10ps

module sfw_protect_tb_top;
  // ==========================================================================
  // signals
  logic        clk;       // 200 MHz system clock
  logic        reset;     // async, active high
  logic        cs_n;      // chip select from the master model
  logic        sck;       // link clock from the master model
  logic        si;        // serial data in
  logic        wp_n;      // write-protect pin
  logic        so;        // serial data out
  logic        so_oe;     // output enable of so
  logic        so_pin;    // so as the master sees it, inverted while released
  logic        nv_load;   // restore pulse for the non-volatile bits
  logic [2:0]  nv_value;  // restored values
  logic        wake_busy; // wake indication
  logic        mem_wr_en; // array byte write strobe
  logic [19:0] mem_addr;  // array write address
  logic [7:0]  mem_wdata; // array write data
  logic [7:0]  status;    // status view
  logic [7:0]  rx;        // last byte seen on so
  int          errors;    // mismatches
  int          checks;    // comparisons
  int          wr_count;  // array writes seen
  int          base;      // wr_count before a burst
  logic [19:0] last_addr; // address of the last array write
  logic [7:0]  last_data; // data of the last array write
  logic [19:0] start_addr [4] = '{20'hbffff, 20'hbffff, 20'h7ffff, 20'hfffff};
  int          exp_cnt    [4] = '{2, 1, 1, 0}; // bytes let through per code

  // ==========================================================================
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================================
  // design and far side
  sfw_protect u_sfw_protect (
    .clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
    .so(so), .so_oe(so_oe), .nv_load(nv_load), .nv_value(nv_value),
    .wake_busy(wake_busy), .mem_wr_en(mem_wr_en), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .protection_status(status));

  // a released line must not keep showing the last driven bit
  assign so_pin = so_oe ? so : ~so;

  sfw_spi_master u_sfw_spi_master (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so_pin));

  // count array writes; the bench only compares differences of the count
  initial wr_count = 0;
  always @(posedge clk) begin
    if (mem_wr_en === 1'b1) begin
      wr_count  <= wr_count + 1;
      last_addr <= mem_addr;
      last_data <= mem_wdata;
    end
  end

  // ==========================================================================
  // helpers
  task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one whole command frame; rx keeps the byte seen during the last byte
  task automatic frame(input logic [7:0] q[$], output logic [7:0] r);
    u_sfw_spi_master.select();
    foreach (q[i]) begin
      u_sfw_spi_master.xfer(q[i], r);
    end
    u_sfw_spi_master.deselect();
  endtask : frame

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    print_verdict();
  end

  // ==========================================================================
  // main sequence
  initial begin
    reset     = 1'b1;
    wp_n      = 1'b1;
    nv_load   = 1'b0;
    nv_value  = 3'h0;
    wake_busy = 1'b0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    check("status after reset", 20'(status), 20'h00040);
    frame('{sfw_pkg::OP_STATUS_READ, 8'h00}, rx);
    check("status read", 20'(rx), 20'h00040);
    // status write without the latch is refused
    frame('{sfw_pkg::OP_STATUS_WRITE, 8'hff}, rx);
    check("locked status write", 20'(status), 20'h00040);
    frame('{sfw_pkg::OP_WRITE_ENABLE}, rx);
    check("latch set", 20'(status), 20'h00042);
    frame('{sfw_pkg::OP_STATUS_READ, 8'h00}, rx);
    check("status read latch", 20'(rx), 20'h00042);
    frame('{sfw_pkg::OP_WRITE_DISABLE}, rx);
    check("latch clear", 20'(status), 20'h00040);
    frame('{sfw_pkg::OP_STATUS_READ, 8'h00}, rx);
    check("reread after disable", 20'(rx), 20'h00040);
    // all ones written: only bits 7,3,2 land, fixed bits hold, latch drops
    frame('{sfw_pkg::OP_WRITE_ENABLE}, rx);
    frame('{sfw_pkg::OP_STATUS_WRITE, 8'hff}, rx);
    check("status all ones", 20'(status), 20'h000cc);
    // pin enabled and pin low: update refused
    wp_n <= 1'b0;
    frame('{sfw_pkg::OP_WRITE_ENABLE}, rx);
    frame('{sfw_pkg::OP_STATUS_WRITE, 8'h00}, rx);
    check("pin blocks status", 20'(status), 20'h000cc);
    wp_n <= 1'b1;
    // every block-protect code, a two-byte burst across its boundary
    for (int c = 0; c < 4; c++) begin
      frame('{sfw_pkg::OP_WRITE_ENABLE}, rx);
      // pin enable set, so a low pin would block the array if it could
      frame('{sfw_pkg::OP_STATUS_WRITE, 8'h80 | 8'(c << 2)}, rx);
      check("protect code", 20'(status), 20'h000c0 | 20'(c << 2));
      wp_n <= 1'b0; // pin low must not stop array writes
      base = wr_count;
      frame('{sfw_pkg::OP_WRITE_ENABLE}, rx);
      frame('{sfw_pkg::OP_ARRAY_WRITE, 8'(start_addr[c] >> 16), 8'(start_addr[c] >> 8),
              8'(start_addr[c]), 8'ha5, 8'h5a}, rx);
      check("bytes written", 20'(wr_count - base), 20'(exp_cnt[c]));
      if (exp_cnt[c] > 0) begin
        check("last address", last_addr, start_addr[c] + 20'(exp_cnt[c] - 1));
        check("last data", 20'(last_data), (exp_cnt[c] == 2) ? 20'h5a : 20'ha5);
      end
      check("latch after write", 20'(status), 20'h000c0 | 20'(c << 2));
      wp_n <= 1'b1;
    end
    // restore of stored bits, then an array write without the latch
    @(posedge clk);
    nv_value <= 3'h0;
    nv_load  <= 1'b1;
    @(posedge clk);
    nv_load <= 1'b0;
    base = wr_count;
    frame('{sfw_pkg::OP_ARRAY_WRITE, 8'h00, 8'h00, 8'h10, 8'h33}, rx);
    check("write without latch", 20'(wr_count - base), 20'h0);
    // pin enable clear: a low pin must not stop the status write
    wp_n <= 1'b0;
    frame('{sfw_pkg::OP_WRITE_ENABLE}, rx);
    frame('{sfw_pkg::OP_STATUS_WRITE, 8'h08}, rx);
    check("pin ignored", 20'(status), 20'h00048);
    wp_n <= 1'b1;
    nv_value <= 3'h5;
    nv_load  <= 1'b1;
    @(posedge clk);
    nv_load <= 1'b0;
    repeat (2) @(posedge clk);
    check("restored bits", 20'(status), 20'h000c4);
    wake_busy <= 1'b1;
    repeat (2) @(posedge clk);
    check("waking bit", 20'(status), 20'h000c5);
    wake_busy <= 1'b0;
    repeat (2) @(posedge clk);
    check("awake bit", 20'(status), 20'h000c4);
    // a second power-up in mid-run drops the latch again
    frame('{sfw_pkg::OP_WRITE_ENABLE}, rx);
    check("latch before reset", 20'(status), 20'h000c6);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    check("status after second reset", 20'(status), 20'h00040);
    frame('{sfw_pkg::OP_STATUS_READ, 8'h00}, rx);
    check("read after second reset", 20'(rx), 20'h00040);
    print_verdict();
  end
endmodule : sfw_protect_tb_top
